// ---- nbc_pkg.sv ----
/*
 Package for the nibble core transfer and skip timing block: opcode classes, skip costs,
 string-effect groups, address field positions and the cycle counts of each instruction kind.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package nbc_pkg;

	// Instruction classes presented by the fetch stage
	typedef enum logic [3:0] {
		NBC_OP_NOP      = 4'h0,
		NBC_OP_LD_INC   = 4'h1,
		NBC_OP_LD_DEC   = 4'h2,
		NBC_OP_XCH_INC  = 4'h3,
		NBC_OP_XCH_DEC  = 4'h4,
		NBC_OP_TBL_PCDE = 4'h5,
		NBC_OP_TBL_PCXA = 4'h6,
		NBC_OP_TBL_BCDE = 4'h7,
		NBC_OP_TBL_BCXA = 4'h8,
		NBC_OP_LDI_A    = 4'h9,
		NBC_OP_LDI_XA   = 4'hA,
		NBC_OP_LDI_HL   = 4'hB,
		NBC_OP_OTHER    = 4'hC
	} nbc_op_e;

	// Length class of the instruction that follows (the one a skip would pass over)
	typedef enum logic [1:0] {
		NBC_LEN_SHORT = 2'h0,
		NBC_LEN_LONG  = 2'h1,
		NBC_LEN_TCALL = 2'h2
	} nbc_len_e;

	// String-effect groups of immediate loads
	typedef enum logic [1:0] {
		NBC_STR_NONE = 2'h0,
		NBC_STR_A    = 2'h1,
		NBC_STR_B    = 2'h2
	} nbc_str_e;

	// Execution states, Gray coded along fetch-exec-rom-skip path
	typedef enum logic [2:0] {
		NBC_ST_IDLE = 3'h0,
		NBC_ST_EXEC = 3'h1,
		NBC_ST_ROM  = 3'h3,
		NBC_ST_SKIP = 3'h2
	} nbc_state_e;

	// Skip penalties in machine cycles
	localparam logic [1:0] NBC_SKIP_NONE  = 2'h0;
	localparam logic [1:0] NBC_SKIP_SHORT = 2'h1;
	localparam logic [1:0] NBC_SKIP_LONG  = 2'h2;
	localparam logic [1:0] NBC_SKIP_TCALL = 2'h1;

	// Base machine cycles
	localparam logic [1:0] NBC_CYC_PTR  = 2'h2;
	localparam logic [1:0] NBC_CYC_TBL  = 2'h3;
	localparam logic [1:0] NBC_CYC_ONE  = 2'h1;
	localparam logic [1:0] NBC_CYC_IMM  = 2'h2;

	// Pointer wrap values
	localparam logic [3:0] NBC_L_WRAP_INC = 4'h0;
	localparam logic [3:0] NBC_L_WRAP_DEC = 4'hF;

	// Address fields
	localparam int NBC_ROM_AW   = 14;
	localparam int NBC_PC_HI    = 13;
	localparam int NBC_PC_LO    = 8;
	localparam int NBC_B_BITS   = 2;

	// CPU clock divider choices, in core_clk cycles per machine cycle
	localparam logic [5:0] NBC_DIV0 = 6'h20;
	localparam logic [5:0] NBC_DIV1 = 6'h10;
	localparam logic [5:0] NBC_DIV2 = 6'h08;
	localparam logic [5:0] NBC_DIV3 = 6'h02;

endpackage : nbc_pkg

// ---- nbc_clkdiv.sv ----
/*
 CPU clock divider: emits one machine-cycle enable pulse per selected period.
 Assumes a single core clock and synchronous active-high reset.
*/
`timescale 1ns/10ps
module nbc_clkdiv (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [1:0] processor_clock_control,
	output logic            mc_en
);

	typedef struct packed {
		logic [5:0] cnt;
		logic       en;
	} nbc_div_s;

	nbc_div_s s_q;
	nbc_div_s s_d;

	// Period lookup, decoded once per cycle
	function automatic logic [5:0] nbc_period(input logic [1:0] sel);
		case (sel)
			2'h0:    nbc_period = nbc_pkg::NBC_DIV0;
			2'h1:    nbc_period = nbc_pkg::NBC_DIV1;
			2'h2:    nbc_period = nbc_pkg::NBC_DIV2;
			default: nbc_period = nbc_pkg::NBC_DIV3;
		endcase
	endfunction : nbc_period

	// Count down; a new setting takes effect at the next period boundary
	always_comb begin
		s_d = s_q;
		s_d.en = 1'b0;
		if (s_q.cnt <= 6'h01) begin
			s_d.cnt = nbc_period(processor_clock_control);
			s_d.en = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt - 6'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign mc_en = s_q.en;

	a_div_period: assert property (@(posedge core_clk) disable iff (rst)
		(mc_en && processor_clock_control == 2'h3 && $past(processor_clock_control) == 2'h3)
		|-> ##2 mc_en)
		else $error("machine cycle enable period wrong");

endmodule : nbc_clkdiv

// ---- nbc_core.sv ----
/*
 Transfer and skip timing unit of a 4-bit core: pointer loads and exchanges with auto step,
 ROM table reads, immediate-load string effect and skip penalty timing.
 Assumes the fetch stage holds an instruction on instr_valid until instr_done, and that data
 memory and ROM answer combinationally to their addresses.
*/
`timescale 1ns/10ps
module nbc_core (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic [1:0]            processor_clock_control,
	input  wire logic                  instr_valid,
	input  wire nbc_pkg::nbc_op_e      instr_op,
	input  wire logic [7:0]            instr_imm,
	input  wire nbc_pkg::nbc_len_e     next_len,
	input  wire logic [13:0]           program_counter,
	input  wire logic [3:0]            reg_b,
	input  wire logic [3:0]            reg_c,
	input  wire logic [7:0]            table_offset_pair,
	input  wire logic [3:0]            mem_rdata,
	input  wire logic [7:0]            rom_rdata,
	output logic                       instr_done,
	output logic                       skip_next,
	output logic [7:0]                 wide_accumulator,
	output logic [7:0]                 pointer_pair,
	output logic [7:0]                 mem_addr,
	output logic                       mem_we,
	output logic [3:0]                 mem_wdata,
	output logic [13:0]                rom_addr,
	output logic                       mc_en
);

	////////////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		nbc_pkg::nbc_state_e st;
		logic [1:0]          cyc;
		logic [1:0]          skp;
		logic                skip;
		logic [7:0]          xa;
		logic [7:0]          hl;
		nbc_pkg::nbc_str_e   last_str;
		logic                done;
		logic                we;
		logic [3:0]          wdata;
		logic [13:0]         raddr;
		logic [7:0]          maddr;
	} nbc_core_s;

	nbc_core_s s_q;
	nbc_core_s s_d;

	nbc_clkdiv u_div (
		.core_clk                (core_clk),
		.rst                     (rst),
		.processor_clock_control (processor_clock_control),
		.mc_en                   (mc_en)
	);

	////////////////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// Base cycle count of each class
	function automatic logic [1:0] nbc_base(input nbc_pkg::nbc_op_e op);
		case (op)
			nbc_pkg::NBC_OP_LD_INC, nbc_pkg::NBC_OP_LD_DEC,
			nbc_pkg::NBC_OP_XCH_INC, nbc_pkg::NBC_OP_XCH_DEC:
				nbc_base = nbc_pkg::NBC_CYC_PTR;
			nbc_pkg::NBC_OP_TBL_PCDE, nbc_pkg::NBC_OP_TBL_PCXA,
			nbc_pkg::NBC_OP_TBL_BCDE, nbc_pkg::NBC_OP_TBL_BCXA:
				nbc_base = nbc_pkg::NBC_CYC_TBL;
			nbc_pkg::NBC_OP_LDI_XA, nbc_pkg::NBC_OP_LDI_HL:
				nbc_base = nbc_pkg::NBC_CYC_IMM;
			default:
				nbc_base = nbc_pkg::NBC_CYC_ONE;
		endcase
	endfunction : nbc_base

	// Skip cost from the length of the instruction being passed over
	function automatic logic [1:0] nbc_skip_cost(input nbc_pkg::nbc_len_e len);
		case (len)
			nbc_pkg::NBC_LEN_LONG:  nbc_skip_cost = nbc_pkg::NBC_SKIP_LONG;
			nbc_pkg::NBC_LEN_TCALL: nbc_skip_cost = nbc_pkg::NBC_SKIP_TCALL;
			default:                nbc_skip_cost = nbc_pkg::NBC_SKIP_SHORT;
		endcase
	endfunction : nbc_skip_cost

	// String-effect group of an immediate load
	function automatic nbc_pkg::nbc_str_e nbc_str(input nbc_pkg::nbc_op_e op);
		case (op)
			nbc_pkg::NBC_OP_LDI_A, nbc_pkg::NBC_OP_LDI_XA: nbc_str = nbc_pkg::NBC_STR_A;
			nbc_pkg::NBC_OP_LDI_HL:                        nbc_str = nbc_pkg::NBC_STR_B;
			default:                                       nbc_str = nbc_pkg::NBC_STR_NONE;
		endcase
	endfunction : nbc_str

	logic [3:0] l_inc;
	logic [3:0] l_dec;
	logic [13:0] tbl_addr;

	assign l_inc = s_q.hl[3:0] + 4'h1;
	assign l_dec = s_q.hl[3:0] - 4'h1;

	// Table address; upper B bits are dropped so the address stays within ROM
	always_comb begin
		case (instr_op)
			nbc_pkg::NBC_OP_TBL_PCDE:
				tbl_addr = {program_counter[nbc_pkg::NBC_PC_HI:nbc_pkg::NBC_PC_LO],
					table_offset_pair};
			nbc_pkg::NBC_OP_TBL_PCXA:
				tbl_addr = {program_counter[nbc_pkg::NBC_PC_HI:nbc_pkg::NBC_PC_LO],
					s_q.xa};
			nbc_pkg::NBC_OP_TBL_BCDE:
				tbl_addr = {reg_b[nbc_pkg::NBC_B_BITS-1:0], reg_c, table_offset_pair};
			default:
				tbl_addr = {reg_b[nbc_pkg::NBC_B_BITS-1:0], reg_c, s_q.xa};
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Sequencer: state steps take place on machine-cycle enables; done and write strobe clear every core cycle

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.we = 1'b0;
		if (mc_en) begin
			case (s_q.st)
				nbc_pkg::NBC_ST_IDLE: begin
					if (instr_valid) begin
						s_d.cyc = nbc_base(instr_op) - 2'h1;
						s_d.skip = 1'b0;
						s_d.st = nbc_pkg::NBC_ST_EXEC;
						if (instr_op == nbc_pkg::NBC_OP_TBL_PCDE ||
							instr_op == nbc_pkg::NBC_OP_TBL_PCXA ||
							instr_op == nbc_pkg::NBC_OP_TBL_BCDE ||
							instr_op == nbc_pkg::NBC_OP_TBL_BCXA) begin
							s_d.raddr = tbl_addr;
							s_d.st = nbc_pkg::NBC_ST_ROM;
						end
						// Effects of the first cycle
						case (instr_op)
							nbc_pkg::NBC_OP_LD_INC: begin
								s_d.xa[3:0] = mem_rdata;
								s_d.hl[3:0] = l_inc;
								s_d.skip = (l_inc == nbc_pkg::NBC_L_WRAP_INC);
							end
							nbc_pkg::NBC_OP_LD_DEC: begin
								s_d.xa[3:0] = mem_rdata;
								s_d.hl[3:0] = l_dec;
								s_d.skip = (l_dec == nbc_pkg::NBC_L_WRAP_DEC);
							end
							nbc_pkg::NBC_OP_XCH_INC: begin
								s_d.xa[3:0] = mem_rdata;
								s_d.we = 1'b1;
								s_d.wdata = s_q.xa[3:0];
								s_d.hl[3:0] = l_inc;
								s_d.skip = (l_inc == nbc_pkg::NBC_L_WRAP_INC);
							end
							nbc_pkg::NBC_OP_XCH_DEC: begin
								s_d.xa[3:0] = mem_rdata;
								s_d.we = 1'b1;
								s_d.wdata = s_q.xa[3:0];
								s_d.hl[3:0] = l_dec;
								s_d.skip = (l_dec == nbc_pkg::NBC_L_WRAP_DEC);
							end
							nbc_pkg::NBC_OP_LDI_A: begin
								if (s_q.last_str != nbc_pkg::NBC_STR_A) begin
									s_d.xa[3:0] = instr_imm[3:0];
								end
							end
							nbc_pkg::NBC_OP_LDI_XA: begin
								if (s_q.last_str != nbc_pkg::NBC_STR_A) begin
									s_d.xa = instr_imm;
								end
							end
							nbc_pkg::NBC_OP_LDI_HL: begin
								if (s_q.last_str != nbc_pkg::NBC_STR_B) begin
									s_d.hl = instr_imm;
								end
							end
							default: begin
							end
						endcase
						s_d.last_str = nbc_str(instr_op);
						// Single-cycle classes finish here
						if (nbc_base(instr_op) == nbc_pkg::NBC_CYC_ONE) begin
							s_d.done = 1'b1;
							s_d.st = nbc_pkg::NBC_ST_IDLE;
						end
					end
				end
				nbc_pkg::NBC_ST_ROM: begin
					// ROM word captured on the last base cycle
					if (s_q.cyc == 2'h1) begin
						s_d.xa = rom_rdata;
						s_d.done = 1'b1;
						s_d.st = nbc_pkg::NBC_ST_IDLE;
					end
					s_d.cyc = s_q.cyc - 2'h1;
				end
				nbc_pkg::NBC_ST_EXEC: begin
					if (s_q.cyc == 2'h1) begin
						if (s_q.skip) begin
							s_d.skp = nbc_skip_cost(next_len);
							s_d.st = nbc_pkg::NBC_ST_SKIP;
						end else begin
							s_d.done = 1'b1;
							s_d.st = nbc_pkg::NBC_ST_IDLE;
						end
					end
					s_d.cyc = s_q.cyc - 2'h1;
				end
				nbc_pkg::NBC_ST_SKIP: begin
					// Extra machine cycles spent passing over the next instruction
					if (s_q.skp == 2'h1) begin
						s_d.done = 1'b1;
						s_d.st = nbc_pkg::NBC_ST_IDLE;
					end
					s_d.skp = s_q.skp - 2'h1;
				end
				default: begin
					s_d.st = nbc_pkg::NBC_ST_IDLE;
				end
			endcase
		end
		// Write cycle keeps the pre-step pointer, else the swap would land one nibble off
		s_d.maddr = s_d.we ? s_q.hl : s_d.hl;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign instr_done       = s_q.done;
	assign skip_next        = s_q.skip;
	assign wide_accumulator = s_q.xa;
	assign pointer_pair     = s_q.hl;
	assign mem_addr         = s_q.maddr; // Pre-step pointer while an exchange writes back
	assign mem_we           = s_q.we;
	assign mem_wdata        = s_q.wdata;
	assign rom_addr         = s_q.raddr;

	////////////////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence nbc_skip_start;
		mc_en && s_q.st == nbc_pkg::NBC_ST_EXEC && s_q.cyc == 2'h1 && s_q.skip;
	endsequence

	a_noskip_done: assert property (@(posedge core_clk) disable iff (rst)
		(mc_en && s_q.st == nbc_pkg::NBC_ST_EXEC && s_q.cyc == 2'h1 && !s_q.skip)
		|=> instr_done)
		else $error("no-skip finish missing");
	a_skip_short: assert property (@(posedge core_clk) disable iff (rst)
		(nbc_skip_start and next_len == nbc_pkg::NBC_LEN_SHORT) |=> s_q.skp == 2'h1)
		else $error("short skip cost wrong");
	a_skip_long: assert property (@(posedge core_clk) disable iff (rst)
		(nbc_skip_start and next_len == nbc_pkg::NBC_LEN_LONG) |=> s_q.skp == 2'h2)
		else $error("long skip cost wrong");
	a_skip_tcall: assert property (@(posedge core_clk) disable iff (rst)
		(nbc_skip_start and next_len == nbc_pkg::NBC_LEN_TCALL) |=> s_q.skp == 2'h1)
		else $error("table call skip cost wrong");
	a_inc_wrap: assert property (@(posedge core_clk) disable iff (rst)
		(mc_en && s_q.st == nbc_pkg::NBC_ST_IDLE && instr_valid &&
		instr_op == nbc_pkg::NBC_OP_LD_INC) |=> (skip_next == (pointer_pair[3:0] == 4'h0)) &&
		wide_accumulator[3:0] == $past(mem_rdata))
		else $error("increment load wrong");
	a_dec_wrap: assert property (@(posedge core_clk) disable iff (rst)
		(mc_en && s_q.st == nbc_pkg::NBC_ST_IDLE && instr_valid &&
		instr_op == nbc_pkg::NBC_OP_LD_DEC) |=> skip_next == (pointer_pair[3:0] == 4'hF))
		else $error("decrement load wrong");
	a_xch_write: assert property (@(posedge core_clk) disable iff (rst)
		(mc_en && s_q.st == nbc_pkg::NBC_ST_IDLE && instr_valid &&
		(instr_op == nbc_pkg::NBC_OP_XCH_INC || instr_op == nbc_pkg::NBC_OP_XCH_DEC))
		|=> mem_we && mem_wdata == $past(wide_accumulator[3:0]) &&
		mem_addr == $past(pointer_pair))
		else $error("exchange write wrong");
	a_tbl_addr: assert property (@(posedge core_clk) disable iff (rst)
		(mc_en && s_q.st == nbc_pkg::NBC_ST_IDLE && instr_valid &&
		instr_op == nbc_pkg::NBC_OP_TBL_BCDE) |=> rom_addr[13:12] == $past(reg_b[1:0]))
		else $error("table address wrong");
	a_tbl_pc: assert property (@(posedge core_clk) disable iff (rst)
		(mc_en && s_q.st == nbc_pkg::NBC_ST_IDLE && instr_valid &&
		instr_op == nbc_pkg::NBC_OP_TBL_PCDE) |=> rom_addr[13:8] == $past(program_counter[13:8]))
		else $error("pc table address wrong");

endmodule : nbc_core

// ---- test_nibble_cpu_transfer_skip_timing.sv ----
/*
 Self-checking testbench for the nibble core transfer and skip timing unit.
 Assumes nbc_pkg and nbc_core are compiled first; the bench models data memory and ROM.
*/
`timescale 1ns/10ps
module test_nibble_cpu_transfer_skip_timing;

	logic              core_clk = 1'b0;
	logic              rst = 1'b1;
	logic [1:0]        processor_clock_control = 2'h3;
	logic              instr_valid = 1'b0;
	nbc_pkg::nbc_op_e  instr_op = nbc_pkg::NBC_OP_NOP;
	logic [7:0]        instr_imm = 8'h00;
	nbc_pkg::nbc_len_e next_len = nbc_pkg::NBC_LEN_SHORT;
	logic [13:0]       program_counter = 14'h2A5C;
	logic [3:0]        reg_b = 4'hE;
	logic [3:0]        reg_c = 4'h9;
	logic [7:0]        table_offset_pair = 8'hD3;
	logic [3:0]        mem_rdata;
	logic [7:0]        rom_rdata;
	logic              instr_done;
	logic              skip_next;
	logic              mem_we;
	logic              mc_en;
	logic [7:0]        wide_accumulator;
	logic [7:0]        pointer_pair;
	logic [7:0]        mem_addr;
	logic [3:0]        mem_wdata;
	logic [13:0]       rom_addr;
	logic [3:0]        mem_arr [256];
	logic [7:0]        exp_xa = 8'h00;
	logic [7:0]        exp_hl = 8'h00;
	int                errors = 0;
	int                n_checks = 0;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Clock and memory models; ROM mixes every address bit so a wrong upper bit shows
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	function automatic logic [7:0] rom_f(input logic [13:0] a);
		return a[7:0] ^ {a[13:8], 2'h0};
	endfunction : rom_f

	assign rom_rdata = rom_f(rom_addr);
	assign mem_rdata = mem_arr[mem_addr];

	// Data memory takes the write strobe on the rising edge
	always @(posedge core_clk) begin
		if (mem_we) begin
			mem_arr[mem_addr] <= mem_wdata;
		end
	end

	nbc_core dut (
		.core_clk                (core_clk),
		.rst                     (rst),
		.processor_clock_control (processor_clock_control),
		.instr_valid             (instr_valid),
		.instr_op                (instr_op),
		.instr_imm               (instr_imm),
		.next_len                (next_len),
		.program_counter         (program_counter),
		.reg_b                   (reg_b),
		.reg_c                   (reg_c),
		.table_offset_pair       (table_offset_pair),
		.mem_rdata               (mem_rdata),
		.rom_rdata               (rom_rdata),
		.instr_done              (instr_done),
		.skip_next               (skip_next),
		.wide_accumulator        (wide_accumulator),
		.pointer_pair            (pointer_pair),
		.mem_addr                (mem_addr),
		.mem_we                  (mem_we),
		.mem_wdata               (mem_wdata),
		.rom_addr                (rom_addr),
		.mc_en                   (mc_en)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	task automatic stop_test;
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	// Counts core cycles to the next machine-cycle pulse, bounded
	task automatic wait_mc(output int gap);
		gap = 0;
		do begin
			@(negedge core_clk);
			gap++;
		end while (!mc_en && gap < 100);
		if (!mc_en) begin
			errors++;
			stop_test();
		end
	endtask : wait_mc

	// Issues one instruction, counts machine cycles from take to done, then judges state.
	// Valid drops on the edge after done, where the divide-by-two pulse is always low.
	task automatic run_op(input nbc_pkg::nbc_op_e op, input logic [7:0] imm,
		input nbc_pkg::nbc_len_e ln, input int exp_mc, input logic exp_skip);
		int   mcs;
		int   k;
		logic started;
		logic fin;
		mcs = 0;
		started = 1'b0;
		fin = 1'b0;
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_imm <= imm;
		next_len <= ln;
		for (k = 0; k < 200 && !fin; k++) begin
			@(negedge core_clk);
			if (started && instr_done) begin
				fin = 1'b1;
			end else if (mc_en) begin
				started = 1'b1;
				mcs++;
			end
		end
		if (!fin) begin
			errors++;
			stop_test();
		end
		if (exp_mc > 0) begin
			check(16'(mcs), 16'(exp_mc), "machine cycles");
		end
		check({15'h0, skip_next}, {15'h0, exp_skip}, "skip flag");
		check({8'h0, wide_accumulator}, {8'h0, exp_xa}, "accumulator");
		check({8'h0, pointer_pair}, {8'h0, exp_hl}, "pointer pair");
		@(posedge core_clk);
		instr_valid <= 1'b0;
	endtask : run_op

	////////////////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_clock_div;
		int                 gap;
		int                 sel;
		logic [5:0]         divs [4];
		divs = '{nbc_pkg::NBC_DIV0, nbc_pkg::NBC_DIV1, nbc_pkg::NBC_DIV2, nbc_pkg::NBC_DIV3};
		for (sel = 0; sel < 4; sel++) begin
			@(posedge core_clk);
			processor_clock_control <= 2'(sel);
			wait_mc(gap);
			wait_mc(gap);
			wait_mc(gap);
			check(16'(gap), {10'h0, divs[sel]}, "cycle period");
		end
		@(posedge core_clk);
		processor_clock_control <= 2'h3;
		wait_mc(gap);
		wait_mc(gap);
	endtask : t_clock_div

	// Loads step L across both wrap points with each skip length
	task automatic t_ptr_loads;
		exp_hl = 8'h3E;
		run_op(nbc_pkg::NBC_OP_LDI_HL, 8'h3E, nbc_pkg::NBC_LEN_SHORT, 2, 1'b0);
		mem_arr[8'h3E] = 4'h5;
		exp_xa[3:0] = 4'h5;
		exp_hl = 8'h3F;
		run_op(nbc_pkg::NBC_OP_LD_INC, 8'h00, nbc_pkg::NBC_LEN_LONG, 2, 1'b0);
		mem_arr[8'h3F] = 4'h9;
		exp_xa[3:0] = 4'h9;
		exp_hl = 8'h30;
		run_op(nbc_pkg::NBC_OP_LD_INC, 8'h00, nbc_pkg::NBC_LEN_SHORT, 3, 1'b1);
		mem_arr[8'h30] = 4'h7;
		exp_xa[3:0] = 4'h7;
		exp_hl = 8'h3F;
		run_op(nbc_pkg::NBC_OP_LD_DEC, 8'h00, nbc_pkg::NBC_LEN_LONG, 4, 1'b1);
		mem_arr[8'h3F] = 4'h2;
		exp_xa[3:0] = 4'h2;
		exp_hl = 8'h3E;
		run_op(nbc_pkg::NBC_OP_LD_DEC, 8'h00, nbc_pkg::NBC_LEN_TCALL, 2, 1'b0);
		exp_hl = 8'h4F;
		run_op(nbc_pkg::NBC_OP_LDI_HL, 8'h4F, nbc_pkg::NBC_LEN_SHORT, 2, 1'b0);
		mem_arr[8'h4F] = 4'hB;
		exp_xa[3:0] = 4'hB;
		exp_hl = 8'h40;
		run_op(nbc_pkg::NBC_OP_LD_INC, 8'h00, nbc_pkg::NBC_LEN_TCALL, 3, 1'b1);
	endtask : t_ptr_loads

	// Exchanges must also write the old accumulator back to memory
	task automatic t_exchange;
		logic [3:0] a0;
		a0 = exp_xa[3:0];
		exp_hl = 8'h2F;
		run_op(nbc_pkg::NBC_OP_LDI_HL, 8'h2F, nbc_pkg::NBC_LEN_SHORT, 2, 1'b0);
		mem_arr[8'h2F] = 4'hC;
		exp_xa[3:0] = 4'hC;
		exp_hl = 8'h20;
		run_op(nbc_pkg::NBC_OP_XCH_INC, 8'h00, nbc_pkg::NBC_LEN_SHORT, 3, 1'b1);
		check({12'h0, mem_arr[8'h2F]}, {12'h0, a0}, "exchange write");
		mem_arr[8'h20] = 4'h6;
		exp_xa[3:0] = 4'h6;
		exp_hl = 8'h2F;
		run_op(nbc_pkg::NBC_OP_XCH_DEC, 8'h00, nbc_pkg::NBC_LEN_LONG, 4, 1'b1);
		check({12'h0, mem_arr[8'h20]}, 16'h000C, "exchange write");
		exp_xa[3:0] = a0;
		exp_hl = 8'h2E;
		run_op(nbc_pkg::NBC_OP_XCH_DEC, 8'h00, nbc_pkg::NBC_LEN_SHORT, 2, 1'b0);
		check({12'h0, mem_arr[8'h2F]}, 16'h0006, "exchange write");
	endtask : t_exchange

	// All four table forms; upper B bits change so only the two low ones may matter
	task automatic t_table;
		int               k;
		logic [13:0]      a;
		logic [3:0]       bv;
		nbc_pkg::nbc_op_e tops [4];
		tops = '{nbc_pkg::NBC_OP_TBL_PCDE, nbc_pkg::NBC_OP_TBL_PCXA,
			nbc_pkg::NBC_OP_TBL_BCDE, nbc_pkg::NBC_OP_TBL_BCXA};
		for (k = 0; k < 4; k++) begin
			bv = {2'(k), 2'h2};
			reg_b <= bv;
			case (k)
				0: a = {program_counter[13:8], table_offset_pair};
				1: a = {program_counter[13:8], exp_xa};
				2: a = {bv[1:0], reg_c, table_offset_pair};
				default: a = {bv[1:0], reg_c, exp_xa};
			endcase
			exp_xa = rom_f(a);
			run_op(tops[k], 8'h00, nbc_pkg::NBC_LEN_SHORT, 3, 1'b0);
			check({2'h0, rom_addr}, {2'h0, a}, "rom address");
		end
	endtask : t_table

	// Runs of same-group immediate loads keep only the first
	task automatic t_string;
		exp_xa = 8'h12;
		run_op(nbc_pkg::NBC_OP_LDI_XA, 8'h12, nbc_pkg::NBC_LEN_SHORT, 2, 1'b0);
		run_op(nbc_pkg::NBC_OP_LDI_XA, 8'h34, nbc_pkg::NBC_LEN_SHORT, 2, 1'b0);
		run_op(nbc_pkg::NBC_OP_LDI_A, 8'h05, nbc_pkg::NBC_LEN_SHORT, 1, 1'b0);
		exp_hl = 8'h55;
		run_op(nbc_pkg::NBC_OP_LDI_HL, 8'h55, nbc_pkg::NBC_LEN_SHORT, 2, 1'b0);
		run_op(nbc_pkg::NBC_OP_LDI_HL, 8'h66, nbc_pkg::NBC_LEN_SHORT, 2, 1'b0);
		exp_xa[3:0] = 4'h7;
		run_op(nbc_pkg::NBC_OP_LDI_A, 8'h07, nbc_pkg::NBC_LEN_SHORT, 1, 1'b0);
		run_op(nbc_pkg::NBC_OP_NOP, 8'h00, nbc_pkg::NBC_LEN_SHORT, 1, 1'b0);
		exp_xa = 8'h34;
		run_op(nbc_pkg::NBC_OP_LDI_XA, 8'h34, nbc_pkg::NBC_LEN_SHORT, 2, 1'b0);
	endtask : t_string

	////////////////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem_arr[i] = 4'(i) ^ 4'(i >> 4);
		end
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		check({12'h0, instr_done, skip_next, mem_we, mc_en}, 16'h0000, "flags after reset");
		check({wide_accumulator, pointer_pair}, 16'h0000, "state after reset");
		check({2'h0, rom_addr}, 16'h0000, "rom address after reset");
		t_clock_div();
		t_ptr_loads();
		t_exchange();
		t_table();
		t_string();
		stop_test();
	end

endmodule : test_nibble_cpu_transfer_skip_timing
